// ===== core/window_decode_defines.vh
// constants for the downstream memory window registers and decode
`ifndef WINDOW_DECODE_DEFINES_VH
`define WINDOW_DECODE_DEFINES_VH

// ----------------------------------------
// configuration offsets (byte addresses)
// ----------------------------------------
`define OFS_MEM_BOTTOM 8'h20
`define OFS_MEM_TOP 8'h22
`define OFS_PF_BOTTOM 8'h24
`define OFS_PF_TOP 8'h26
`define OFS_PF_BOTTOM_UPPER 8'h28
`define OFS_PF_TOP_UPPER 8'h2c

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define FIELD_HI 15
`define FIELD_LO 4
`define NIBBLE_HI 3
`define MEM_NIBBLE 4'h0
`define WIDE_ADDR_NIBBLE 4'h1
`define RST_MEM_REG 16'h0000
`define RST_PF_REG 16'h0001
`define RST_UPPER 32'h0000_0000
`define LOW_ZERO 20'h00000
`define LOW_ONES 20'hfffff

`endif

// ===== core/window_field_reg.v
// one 16-bit window register: 12 writable bits over a fixed low nibble
`timescale 1ns/10ps
`default_nettype none
`include "window_decode_defines.vh"

module window_field_reg #(
   parameter [3:0] NIBBLE = 4'h0
) (
   input wire sys_clk,
   input wire reset,
   input wire wr_en,
   input wire [1:0] wr_be,
   input wire [15:0] wr_data,
   output wire [15:0] value,
   output wire [11:0] field
);

   reg [11:0] field_r;

   always @(posedge sys_clk)
   begin
      if (reset)
         field_r <= 12'h000;
      else if (wr_en)
      begin
         // low nibble of byte 0 never stored
         if (wr_be[0])
            field_r[3:0] <= wr_data[7:4];
         if (wr_be[1])
            field_r[11:4] <= wr_data[15:8];
      end
   end

   assign field = field_r;
   assign value = {field_r, NIBBLE}; // RULE4 RULE8 RULE13
endmodule // window_field_reg

`default_nettype wire

// ===== core/window_range_match.v
// inclusive 64-bit range compare with empty-window guard
`timescale 1ns/10ps
`default_nettype none

module window_range_match (
   input wire [63:0] addr,
   input wire [63:0] bottom,
   input wire [63:0] top,
   output wire hit
);

   // base above limit disables the window entirely
   assign hit = (bottom <= top) && (addr >= bottom) && (addr <= top); // RULE12
endmodule // window_range_match

`default_nettype wire

// ===== core/downstream_mem_window_decode.v
// downstream port memory window registers and forwarding decode
// ----------------------------------------
// Overview of operation
// RULE1 - forward memory requests downstream only when address lies inside a window
// RULE2 - memory bottom field bits 15:4 give address 31:20, low 20 bits zero
// RULE3 - memory top field bits 15:4 give address 31:20, low 20 bits ones
// RULE4 - memory bottom and top low nibble reads as zero, not writable
// RULE5 - memory bottom and top registers reset to zero
// RULE6 - prefetch bottom field bits 15:4 give address 31:20, low bits zero
// RULE7 - prefetch top field bits 15:4 give address 31:20, low bits ones
// RULE8 - prefetch low nibble read-only one, wide address support; resets to one
// RULE9 - prefetch bottom address bits 63:32 come from upper bottom register
// RULE10 - prefetch top address bits 63:32 come from upper top register
// RULE11 - upper bottom at 28h, upper top at 2Ch, 32-bit read/write, reset zero
// RULE12 - compare inclusive; bottom above top matches nothing
// RULE13 - writes to read-only low nibbles are ignored
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "window_decode_defines.vh"

module downstream_mem_window_decode (
   input wire sys_clk,
   input wire reset,
   input wire cfg_wr,
   input wire cfg_rd,
   input wire [7:0] cfg_addr,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   output reg [31:0] cfg_rdata,
   output reg cfg_rvalid,
   input wire req_valid,
   input wire req_is_mem,
   input wire [63:0] req_addr,
   output reg fwd_valid,
   output reg fwd_downstream,
   output reg fwd_hit_mem,
   output reg fwd_hit_pf
);

   // ----------------------------------------
   // configuration writes
   // ----------------------------------------
   // dword-aligned access: 20h holds bottom/top in lanes 0-1 / 2-3
   wire [7:0] dw_addr = {cfg_addr[7:2], 2'b00};
   wire wr_mem = cfg_wr && (dw_addr == `OFS_MEM_BOTTOM);
   wire wr_pf = cfg_wr && (dw_addr == `OFS_PF_BOTTOM);
   wire wr_pf_up_lo = cfg_wr && (dw_addr == `OFS_PF_BOTTOM_UPPER);
   wire wr_pf_up_hi = cfg_wr && (dw_addr == `OFS_PF_TOP_UPPER);

   wire [15:0] mem_bottom_val;
   wire [15:0] mem_top_val;
   wire [15:0] pf_bottom_val;
   wire [15:0] pf_top_val;
   wire [11:0] mem_window_low_field;
   wire [11:0] mem_window_high_field;
   wire [11:0] pf_window_low_field;
   wire [11:0] pf_window_high_field;

   window_field_reg #(.NIBBLE(`MEM_NIBBLE)) u_mem_bottom (
      .sys_clk(sys_clk),
      .reset(reset), // RULE5
      .wr_en(wr_mem),
      .wr_be(cfg_be[1:0]),
      .wr_data(cfg_wdata[15:0]),
      .value(mem_bottom_val),
      .field(mem_window_low_field)
   );

   window_field_reg #(.NIBBLE(`MEM_NIBBLE)) u_mem_top (
      .sys_clk(sys_clk),
      .reset(reset), // RULE5
      .wr_en(wr_mem),
      .wr_be(cfg_be[3:2]),
      .wr_data(cfg_wdata[31:16]),
      .value(mem_top_val),
      .field(mem_window_high_field)
   );

   window_field_reg #(.NIBBLE(`WIDE_ADDR_NIBBLE)) u_pf_bottom (
      .sys_clk(sys_clk),
      .reset(reset), // RULE8
      .wr_en(wr_pf),
      .wr_be(cfg_be[1:0]),
      .wr_data(cfg_wdata[15:0]),
      .value(pf_bottom_val),
      .field(pf_window_low_field)
   );

   window_field_reg #(.NIBBLE(`WIDE_ADDR_NIBBLE)) u_pf_top (
      .sys_clk(sys_clk),
      .reset(reset), // RULE8
      .wr_en(wr_pf),
      .wr_be(cfg_be[3:2]),
      .wr_data(cfg_wdata[31:16]),
      .value(pf_top_val),
      .field(pf_window_high_field)
   );

   // ----------------------------------------
   // upper 32 bits of the prefetch window
   // ----------------------------------------
   reg [31:0] pf_bottom_upper_r;
   reg [31:0] pf_top_upper_r;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_upper_lane
         always @(posedge sys_clk)
         begin
            if (reset)
            begin
               pf_bottom_upper_r[g*8 +: 8] <= 8'h00; // RULE11
               pf_top_upper_r[g*8 +: 8] <= 8'h00; // RULE11
            end
            else
            begin
               if (wr_pf_up_lo && cfg_be[g])
                  pf_bottom_upper_r[g*8 +: 8] <= cfg_wdata[g*8 +: 8]; // RULE11
               if (wr_pf_up_hi && cfg_be[g])
                  pf_top_upper_r[g*8 +: 8] <= cfg_wdata[g*8 +: 8]; // RULE11
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // configuration reads
   // ----------------------------------------
   reg [31:0] rdata_nxt;

   always @*
   begin
      case (dw_addr)
         `OFS_MEM_BOTTOM: rdata_nxt = {mem_top_val, mem_bottom_val}; // RULE4
         `OFS_PF_BOTTOM: rdata_nxt = {pf_top_val, pf_bottom_val}; // RULE8
         `OFS_PF_BOTTOM_UPPER: rdata_nxt = pf_bottom_upper_r;
         `OFS_PF_TOP_UPPER: rdata_nxt = pf_top_upper_r;
         // other offsets belong to neighbouring header logic
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         cfg_rdata <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rvalid <= cfg_rd;
         if (cfg_rd)
            cfg_rdata <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // window limits as full addresses
   // ----------------------------------------
   wire [63:0] mem_bottom_addr = {32'h0000_0000, mem_window_low_field, `LOW_ZERO}; // RULE2
   wire [63:0] mem_top_addr = {32'h0000_0000, mem_window_high_field, `LOW_ONES}; // RULE3
   wire [63:0] pf_bottom_addr = {pf_bottom_upper_r, pf_window_low_field, `LOW_ZERO}; // RULE6 RULE9
   wire [63:0] pf_top_addr = {pf_top_upper_r, pf_window_high_field, `LOW_ONES}; // RULE7 RULE10

   wire hit_mem;
   wire hit_pf;

   window_range_match u_mem_match (
      .addr(req_addr),
      .bottom(mem_bottom_addr),
      .top(mem_top_addr),
      .hit(hit_mem)
   );

   window_range_match u_pf_match (
      .addr(req_addr),
      .bottom(pf_bottom_addr),
      .top(pf_top_addr),
      .hit(hit_pf)
   );

   // ----------------------------------------
   // forwarding decision
   // ----------------------------------------
   // registered so every output leaves a flop; costs one cycle of latency
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         fwd_valid <= 1'b0;
         fwd_downstream <= 1'b0;
         fwd_hit_mem <= 1'b0;
         fwd_hit_pf <= 1'b0;
      end
      else
      begin
         fwd_valid <= req_valid;
         fwd_hit_mem <= req_valid && req_is_mem && hit_mem;
         fwd_hit_pf <= req_valid && req_is_mem && hit_pf;
         fwd_downstream <= req_valid && req_is_mem && (hit_mem || hit_pf); // RULE1
      end
   end

endmodule // downstream_mem_window_decode

`default_nettype wire

// ===== bench/dmwd_properties.sv
// port assertions for the memory window decode
`timescale 1ns/10ps
`default_nettype none
module dmwd_checker (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic req_valid,
   input wire logic req_is_mem,
   input wire logic fwd_valid,
   input wire logic fwd_downstream,
   input wire logic fwd_hit_mem,
   input wire logic fwd_hit_pf
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_rd(a);
      cfg_rd && cfg_addr[7:2] == a;
   endsequence
   property p_fwd; req_valid |=> fwd_valid; endproperty
   a_fwd: assert property (p_fwd) else $error("no answer");
   property p_idle; !req_valid |=> !fwd_valid; endproperty
   a_idle: assert property (p_idle) else $error("stray answer");
   property p_nonmem; req_valid && !req_is_mem |=> !fwd_downstream; endproperty
   a_nonmem: assert property (p_nonmem) else $error("non-memory forwarded");
   property p_or; fwd_valid |-> fwd_downstream == (fwd_hit_mem || fwd_hit_pf); endproperty
   a_or: assert property (p_or) else $error("forward not window hit");
   property p_rv; cfg_rd |=> cfg_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("read unanswered");
   property p_rvone; !cfg_rd |=> !cfg_rvalid; endproperty
   a_rvone: assert property (p_rvone) else $error("stray read answer");
   property p_memnib; s_rd(6'h08) |=> cfg_rdata[3:0] == 4'h0 && cfg_rdata[19:16] == 4'h0;
   endproperty
   a_memnib: assert property (p_memnib) else $error("memory nibble not zero");
   property p_pfnib; s_rd(6'h09) |=> cfg_rdata[3:0] == 4'h1 && cfg_rdata[19:16] == 4'h1;
   endproperty
   a_pfnib: assert property (p_pfnib) else $error("wide nibble not one");
endmodule // dmwd_checker
bind downstream_mem_window_decode dmwd_checker i_dmwd_checker (.sys_clk(sys_clk),
   .reset(reset), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
   .cfg_rvalid(cfg_rvalid), .req_valid(req_valid), .req_is_mem(req_is_mem),
   .fwd_valid(fwd_valid), .fwd_downstream(fwd_downstream), .fwd_hit_mem(fwd_hit_mem),
   .fwd_hit_pf(fwd_hit_pf));
`default_nettype wire

// ===== bench/fwd_partner.sv
// packet side model: issues requests, captures forward results
`timescale 1ns/10ps
`default_nettype none
module fwd_partner (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic go_mem,
   input wire logic [63:0] go_addr,
   output logic req_valid = 1'b0,
   output logic req_is_mem = 1'b0,
   output logic [63:0] req_addr = 64'h0,
   input wire logic fwd_valid,
   input wire logic [2:0] fwd_bits,
   output logic seen_r = 1'b0,
   output logic [2:0] got_r = 3'h0
);
   always @(posedge sys_clk)
   begin
      req_valid <= go;
      req_is_mem <= go_mem;
      // idle address flips so a stale value is never mistaken for a request
      req_addr <= go ? go_addr : ~req_addr;
      seen_r <= fwd_valid;
      got_r <= fwd_bits;
   end
endmodule // fwd_partner
`default_nettype wire

// ===== bench/downstream_mem_window_decode_bench.sv
// self-checking bench for the memory window decode
`timescale 1ns/10ps
`default_nettype none
module downstream_mem_window_decode_bench;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic go = 1'b0;
   logic go_mem = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [63:0] go_addr = 64'h0;
   logic [63:0] req_addr;
   logic [31:0] cfg_rdata;
   logic [2:0] got_r;
   logic cfg_rvalid, req_valid, req_is_mem, fwd_valid;
   logic fwd_downstream, fwd_hit_mem, fwd_hit_pf, seen_r;
   int mismatches = 0;
   int check_count = 0;
   initial forever #5 sys_clk = ~sys_clk;
   downstream_mem_window_decode i_downstream_mem_window_decode (.sys_clk(sys_clk),
      .reset(reset), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .req_valid(req_valid), .req_is_mem(req_is_mem), .req_addr(req_addr),
      .fwd_valid(fwd_valid), .fwd_downstream(fwd_downstream), .fwd_hit_mem(fwd_hit_mem),
      .fwd_hit_pf(fwd_hit_pf));
   fwd_partner i_fwd_partner (.sys_clk(sys_clk), .go(go), .go_mem(go_mem), .go_addr(go_addr),
      .req_valid(req_valid), .req_is_mem(req_is_mem), .req_addr(req_addr),
      .fwd_valid(fwd_valid), .fwd_bits({fwd_downstream, fwd_hit_mem, fwd_hit_pf}),
      .seen_r(seen_r), .got_r(got_r));
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_fwd(input logic [2:0] g, input logic [2:0] e);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge sys_clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_be <= b;
      cfg_wdata <= d;
      @(posedge sys_clk);
      cfg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge sys_clk);
      cfg_rd <= 1'b0;
      #1;
      chk(cfg_rdata, e);
      chk({31'h0, cfg_rvalid}, 32'h1);
   endtask
   // result bits are {downstream, memory hit, prefetch hit}
   task automatic req(input logic [63:0] a, input logic m, input logic [2:0] e);
      int n;
      @(posedge sys_clk);
      go <= 1'b1;
      go_mem <= m;
      go_addr <= a;
      @(posedge sys_clk);
      go <= 1'b0;
      for (n = 0; n < 4 && seen_r !== 1'b1; n++)
      begin
         @(posedge sys_clk);
         #1;
      end
      if (seen_r !== 1'b1)
      begin
         mismatches++;
         conclude();
      end
      else
         chk_fwd(got_r, e);
   endtask
   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      rd(8'h20, 32'h0000_0000);
      rd(8'h24, 32'h0001_0001);
      rd(8'h2c, 32'h0);
      rd(8'h30, 32'h0);
      wr(8'h20, 4'hf, 32'h00ff_001f);
      rd(8'h20, 32'h00f0_0010);
      req(64'h0010_0000, 1'b1, 3'h6);
      req(64'h000f_ffff, 1'b1, 3'h5);
      req(64'h00ff_ffff, 1'b1, 3'h6);
      req(64'h0100_0000, 1'b1, 3'h0);
      req(64'h0010_0000, 1'b0, 3'h0);
      wr(8'h24, 4'hf, 32'h002f_001e);
      wr(8'h28, 4'hf, 32'h1);
      wr(8'h2c, 4'hf, 32'h1);
      rd(8'h24, 32'h0021_0011);
      rd(8'h28, 32'h1);
      req(64'h1_0010_0000, 1'b1, 3'h5);
      req(64'h1_002f_ffff, 1'b1, 3'h5);
      req(64'h1_0030_0000, 1'b1, 3'h0);
      req(64'h1_000f_ffff, 1'b1, 3'h0);
      wr(8'h20, 4'h3, 32'h0000_0020);
      req(64'h0025_0000, 1'b1, 3'h6);
      wr(8'h22, 4'hc, 32'h0010_0000);
      rd(8'h20, 32'h0010_0020);
      req(64'h0015_0000, 1'b1, 3'h0);
      req(64'h0020_0000, 1'b1, 3'h0);
      @(posedge sys_clk);
      reset <= 1'b1;
      @(posedge sys_clk);
      reset <= 1'b0;
      rd(8'h20, 32'h0000_0000);
      rd(8'h24, 32'h0001_0001);
      rd(8'h28, 32'h0);
      req(64'h000f_ffff, 1'b1, 3'h7);
      conclude();
   end
endmodule // downstream_mem_window_decode_bench
`default_nettype wire
